/* File: bench/lad_fe_model.sv */
// Front-end model: slicer, level detector and clock sources
`timescale 1ns/100ps
module lad_fe_model (
  input  wire logic           i_clk,
  input  wire logic           i_resetn,
  input  wire logic           i_req,
  input  wire logic           i_mark,
  input  wire logic           i_amp,
  output logic                o_tick,
  output lad_pkg::lad_rails_t o_rail,
  output logic                o_lvl,
  output logic                o_mclk
);
  import lad_pkg::*;
  logic       pol_r;
  logic [1:0] div_r;
  // Master clock at a quarter of the core rate
  assign o_mclk = div_r[1];
  // One bit per request, marks alternate; rails inverted every cycle between bits
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_tick <= 1'h0;
      o_rail <= '0;
      o_lvl  <= 1'h0;
      pol_r  <= 1'h0;
      div_r  <= 2'h0;
    end else begin
      div_r  <= div_r + 2'h1;
      o_tick <= i_req;
      o_lvl  <= i_req & i_mark & i_amp;
      o_rail <= ~o_rail;
      if (i_req) begin
        o_rail <= i_mark ? {pol_r, ~pol_r} : 2'h0;
        pol_r  <= pol_r ^ i_mark;
      end
    end
  end
endmodule

/* File: bench/tb_top.sv */
// Testbench for the line loss and alarm detector
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin \
  n_checks++; \
  if ((got) !== (ex)) begin \
    n_errors++; \
    $display("[FAIL] %s exp %h got %h", nm, ex, got); \
  end \
end
module tb_top;
  import lad_pkg::*;
  logic        clk = 1'h0;
  logic        rstn = 1'h0;
  logic        cfg_wr = 1'h0;
  logic        code_wr = 1'h0;
  logic        req = 1'h0;
  logic        mk = 1'h0;
  logic        amp = 1'h0;
  logic        ce = 1'h1;
  logic [4:0]  code = 5'h00;
  lad_cfg_t    c = '0;
  lad_rails_t  txd = 2'h3;
  logic        tick, lvl, mclk, pm, los, ais, rco;
  lad_rails_t  rail, rxr, lo;
  lad_thresh_t thr;
  lad_cfg_t    ocfg;
  logic [4:0]  ocode;
  int          n_errors = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          n, m, zl;
  int          nt[4] = '{32, 2048, 175, 1544};
  logic [4:0]  codes[6] = '{5'h00, 5'h01, 5'h0a, 5'h15, 5'h16, 5'h1f};

  lad_fe_model i_lad_fe_model (
    .i_clk(clk), .i_resetn(rstn), .i_req(req), .i_mark(mk), .i_amp(amp),
    .o_tick(tick), .o_rail(rail), .o_lvl(lvl), .o_mclk(mclk)
  );

  lad_detector #(.E1_BLK(16), .T1_BLK(64)) i_lad_detector (
    .i_core_clk(clk), .i_resetn(rstn), .i_ce(ce), .i_cfg_wr(cfg_wr), .i_cfg(c),
    .i_code_wr(code_wr), .i_absence_threshold_code(code), .i_bit_tick(tick),
    .i_line_in(rail), .i_lvl_above_decl(lvl), .i_lvl_above_clr(lvl),
    .i_recovered_clock(tick), .i_master_clock(mclk), .i_tx_data(txd),
    .o_thresh(thr), .o_cfg(ocfg), .o_absence_threshold_code(ocode),
    .o_signal_absent_out(los), .o_alarm_signal_status(ais),
    .o_recovered_clock_out(rco), .o_rx_rail(rxr), .o_line_out(lo)
  );

  // 20 MHz clock
  initial begin
    forever #25 clk = ~clk;
  end

  // Config word from mode, standard, criteria and {rxones,txones,cdr,pd}
  function automatic lad_cfg_t cf(lad_haul_t h, logic s, logic k, logic [3:0] f);
    return lad_cfg_t'{h, s, k, f[3], f[2], f[1], f[0]};
  endfunction

  // Long-haul levels: 2 dB steps from 4 dB, capped at 48, clear 4 dB above
  function automatic lad_thresh_t lh(logic [4:0] k);
    logic [11:0] d;
    d = (k > 5'h16) ? 12'h030 : 12'h004 + {6'h0, k, 1'h0};
    return {1'h1, d, d - 12'h004};
  endfunction

  task automatic settle;
    @(posedge clk);
    @(negedge clk);
  endtask

  // Send k bits, each two cycles long
  task automatic bits(input int k, input logic v, input logic a = 1'h1);
    for (int i = 0; i < k; i++) begin
      @(posedge clk);
      req <= 1'h1;
      mk  <= v;
      amp <= a;
      @(posedge clk);
      req <= 1'h0;
    end
  endtask

  // Config write (cw high) or threshold code write
  task automatic wr(input lad_cfg_t v, input logic [4:0] k, input logic cw);
    @(posedge clk);
    c       <= v;
    code    <= k;
    cfg_wr  <= cw;
    code_wr <= ~cw;
    @(posedge clk);
    cfg_wr  <= 1'h0;
    code_wr <= 1'h0;
    settle;
  endtask

  task automatic tend(input string s);
    $display("test %s done", s);
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Cycle ceiling against hangs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      test_done;
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'h1;
    @(negedge clk);
    `CHK("cfg_rst", cf(LAD_SHORT, 1'h0, 1'h0, 4'h2), ocfg)
    `CHK("code_rst", 5'h15, ocode)
    settle;
    settle;
    `CHK("thr_short", {1'h0, 12'h320, 12'h3e8}, thr)
    wr(cf(LAD_MONITOR, 1'h0, 1'h0, 4'h2), code, 1'h1);
    `CHK("thr_mon", {1'h0, 12'h640, 12'h7d0}, thr)
    // Spare mode code falls back to the short-haul levels
    wr(cf(lad_haul_t'(2'h3), 1'h0, 1'h0, 4'h2), code, 1'h1);
    `CHK("thr_spare", {1'h0, 12'h320, 12'h3e8}, thr)
    wr(cf(LAD_LONG, 1'h0, 1'h0, 4'h2), code, 1'h1);
    `CHK("thr_lh_rst", lh(5'h15), thr)
    foreach (codes[i]) begin
      wr(c, codes[i], 1'h0);
      `CHK("thr_lh", lh(codes[i]), thr)
    end
    tend("thresholds");
    // Declare and clear counts for every standard and criteria pair
    for (int r = 0; r < 4; r++) begin
      m  = r[1] ? 128 : 32;
      zl = r[1] ? 100 : 16;
      n  = nt[r];
      wr(cf(LAD_SHORT, r[1], r[0], 4'h2), code, 1'h1);
      bits(m, 1'h1);
      bits(n - 1, 1'h0);
      settle;
      `CHK("los_early", 1'h0, los)
      bits(1, 1'h1);
      bits(n - 1, 1'h0);
      settle;
      `CHK("los_restart", 1'h0, los)
      bits(1, 1'h0);
      settle;
      `CHK("los_set", 1'h1, los)
      bits(1, 1'h1);
      bits(zl, 1'h0);
      bits(m - 1 - zl, 1'h1);
      settle;
      `CHK("los_zrun", 1'h1, los)
      bits(1, 1'h1, 1'h0);
      // Two sparse marks fill a window below one-in-eight density
      for (int j = 0; j < 2; j++) begin
        bits(1, 1'h1);
        bits(zl - 1, 1'h0);
      end
      settle;
      `CHK("los_dens", 1'h1, los)
      bits(m - 1, 1'h1);
      settle;
      `CHK("los_weak", 1'h1, los)
      bits(1, 1'h1);
      settle;
      `CHK("los_clr", 1'h0, los)
    end
    tend("loss");
    wr(cf(LAD_SHORT, 1'h0, 1'h0, 4'he), code, 1'h1);
    `CHK("line_pass", txd, lo)
    // Ticks while the clock enable is low are lost
    @(posedge clk);
    ce <= 1'h0;
    bits(32, 1'h0);
    settle;
    `CHK("ce_frozen", 1'h0, los)
    @(posedge clk);
    ce <= 1'h1;
    bits(32, 1'h0);
    settle;
    for (int i = 0; i < 8; i++) begin
      pm = mclk;
      @(negedge clk);
      `CHK("rclk_sub", pm, rco)
      `CHK("rx_ones", 1'h1, ^rxr)
      `CHK("tx_ones", 1'h1, ^lo)
    end
    wr(cf(LAD_SHORT, 1'h0, 1'h0, 4'h2), code, 1'h1);
    bits(1, 1'h0);
    settle;
    `CHK("rx_follow", 2'h0, rxr)
    `CHK("rclk_follow", 1'h1, rco)
    `CHK("line_norm", txd, lo)
    wr(cf(LAD_SHORT, 1'h0, 1'h0, 4'h3), code, 1'h1);
    `CHK("pd_los", 1'h0, los)
    `CHK("pd_clk", 1'h0, rco)
    `CHK("pd_rx", 2'h0, rxr)
    wr(cf(LAD_SHORT, 1'h0, 1'h0, 4'h2), code, 1'h1);
    `CHK("pd_off", 1'h1, los)
    bits(32, 1'h1);
    tend("outputs");
    // Alarm windows restart while recovery is off
    wr(cf(LAD_SHORT, 1'h0, 1'h0, 4'h0), code, 1'h1);
    wr(cf(LAD_SHORT, 1'h0, 1'h0, 4'h2), code, 1'h1);
    bits(32, 1'h1);
    settle;
    `CHK("ais_e1_set", 1'h1, ais)
    for (int i = 0; i < 2; i++) begin
      bits(13, 1'h1);
      bits(3, 1'h0);
      settle;
      `CHK("ais_e1_clr", ~i[0], ais)
    end
    wr(cf(LAD_SHORT, 1'h1, 1'h0, 4'h0), code, 1'h1);
    wr(cf(LAD_SHORT, 1'h1, 1'h0, 4'h2), code, 1'h1);
    for (int i = 0; i < 3; i++) begin
      bits(56 - i[0], 1'h1);
      bits(8 + i[0], 1'h0);
      settle;
      `CHK("ais_t1", ~i[0], ais)
    end
    wr(cf(LAD_SHORT, 1'h1, 1'h0, 4'h0), code, 1'h1);
    `CHK("ais_off", 1'h0, ais)
    tend("alarm");
    test_done;
  end
endmodule

/* File: hdl/lad_alarm_det.sv */
// All-ones alarm detector counting zeros per bit window
`timescale 1ns/100ps
`include "lad_map.svh"
module lad_alarm_det #(
  parameter int E1_BLK = 512,
  parameter int T1_BLK = 8192
) (
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_ce,
  input  wire logic i_enable,
  input  wire logic i_t1,
  input  wire logic i_tick,
  input  wire logic i_mark,
  output logic      o_status
);
  import lad_pkg::*;

  logic [13:0] bit_cnt_r;
  logic [3:0]  zeros_r;
  logic        prev_low_r;
  wire  [13:0] blk_len  = i_t1 ? 14'(T1_BLK) : 14'(E1_BLK);
  wire         blk_end  = i_tick && (bit_cnt_r == blk_len - 14'h0001);
  wire  [3:0]  zeros_nx = (i_tick && !i_mark && !(&zeros_r)) ? zeros_r + 4'h1 : zeros_r;
  wire  [3:0]  zthr     = i_t1 ? `LAD_T1_ZTHR : `LAD_E1_ZTHR;
  wire         blk_low  = zeros_nx < zthr;

  // Window counting; E1 needs two matching blocks, T1 decides per window
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bit_cnt_r  <= 14'h0000;
      zeros_r    <= 4'h0;
      prev_low_r <= 1'b0;
      o_status   <= 1'b0;
    end else if (i_ce) begin
      if (!i_enable) begin
        bit_cnt_r  <= 14'h0000;
        zeros_r    <= 4'h0;
        prev_low_r <= 1'b0;
        o_status   <= 1'b0;
      end else if (blk_end) begin
        bit_cnt_r  <= 14'h0000;
        zeros_r    <= 4'h0;
        prev_low_r <= blk_low;
        if (i_t1) begin
          o_status <= blk_low;
        // E1 declare on two low blocks
        end else if (blk_low && prev_low_r) begin
          o_status <= 1'b1;
        // E1 clear on two dense blocks
        end else if (!blk_low && !prev_low_r) begin
          o_status <= 1'b0;
        end
      end else begin
        bit_cnt_r <= i_tick ? bit_cnt_r + 14'h0001 : bit_cnt_r;
        zeros_r   <= zeros_nx;
      end
    end
  end

  a_alarm_off_low: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    (i_ce && !i_enable) |=> !o_status)
    else $error("alarm status set while recovery disabled");

  a_alarm_on_block: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    $rose(o_status) |-> $past(blk_end && blk_low))
    else $error("alarm raised away from a low block end");

  a_alarm_clr_block: assert property (
    @(posedge i_clk) disable iff (!i_resetn)
    $fell(o_status) && $past(i_enable) |-> $past(blk_end && !blk_low))
    else $error("alarm cleared away from a dense block end");

  c_alarm_set: cover property (@(posedge i_clk) disable iff (!i_resetn) $rose(o_status));

endmodule

/* File: hdl/lad_detector.sv */
// Loss-of-signal detector with all-ones substitution and alarm status
`timescale 1ns/100ps
`include "lad_map.svh"
module lad_detector #(
  parameter int E1_BLK = 512,
  parameter int T1_BLK = 8192
) (
  input  wire logic                i_core_clk,
  input  wire logic                i_resetn,
  input  wire logic                i_ce,
  input  wire logic                i_cfg_wr,
  input  wire lad_pkg::lad_cfg_t   i_cfg,
  input  wire logic                i_code_wr,
  input  wire logic [4:0]          i_absence_threshold_code,
  input  wire logic                i_bit_tick,
  input  wire lad_pkg::lad_rails_t i_line_in,
  input  wire logic                i_lvl_above_decl,
  input  wire logic                i_lvl_above_clr,
  input  wire logic                i_recovered_clock,
  input  wire logic                i_master_clock,
  input  wire lad_pkg::lad_rails_t i_tx_data,
  output lad_pkg::lad_thresh_t     o_thresh,
  output lad_pkg::lad_cfg_t        o_cfg,
  output logic [4:0]               o_absence_threshold_code,
  output logic                     o_signal_absent_out,
  output logic                     o_alarm_signal_status,
  output logic                     o_recovered_clock_out,
  output lad_pkg::lad_rails_t      o_rx_rail,
  output lad_pkg::lad_rails_t      o_line_out
);
  import lad_pkg::*;

  lad_cfg_t    cfg_r;
  logic [4:0]  code_r;
  lad_loss_t   loss_r;
  lad_loss_t   loss_nxt;
  lad_thresh_t thresh_nxt;
  logic        active_r;
  logic        mclk_q_r;
  logic        pol_r;
  logic [11:0] decl_cnt;
  logic [11:0] win_cnt;
  logic [7:0]  mark_cnt;
  logic [6:0]  zrun_cnt;

  // Configuration and threshold code, loaded by strobes
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_r  <= '{haul: LAD_SHORT, line_standard_select: `LAD_STD_RST,
                 criteria_select: `LAD_CRIT_RST, rx_ones_en: `LAD_RXONES_RST,
                 tx_ones_on_absence: `LAD_TXONES_RST, cdr_en: `LAD_CDR_RST,
                 rx_power_down: `LAD_PD_RST};
      code_r <= `LAD_CODE_RST;
    end else if (i_ce) begin
      if (i_cfg_wr) begin
        cfg_r <= i_cfg;
      end
      if (i_code_wr) begin
        code_r <= i_absence_threshold_code;
      end
    end
  end

  assign o_cfg                    = cfg_r;
  assign o_absence_threshold_code = code_r;

  // Per-standard counts and limits
  wire         is_t1   = cfg_r.line_standard_select;
  wire         crit    = cfg_r.criteria_select;
  wire         pd      = cfg_r.rx_power_down;
  wire  [11:0] n_val   = is_t1 ? (crit ? `LAD_T1_N_ALT : `LAD_T1_N_STD)
                               : (crit ? `LAD_E1_N_ALT : `LAD_E1_N_STD);
  wire  [11:0] m_val   = is_t1 ? `LAD_T1_M : `LAD_E1_M;
  wire  [6:0]  zmax    = is_t1 ? `LAD_T1_ZMAX : `LAD_E1_ZMAX;

  // Long-haul level: 4 dB plus 2 dB per code step, clamped at 48 dB
  wire  [11:0] lh_mag  = (code_r >= `LAD_LH_SAT_CODE) ? `LAD_LH_MAX_DB
                       : `LAD_LH_BASE_DB + {6'h00, code_r, 1'b0};

  // Threshold request for the current mode
  always_comb begin
    thresh_nxt = '0;
    unique case (cfg_r.haul)
      // long-haul coded level with 4 dB hysteresis
      LAD_LONG: begin
        thresh_nxt.long_db  = 1'b1;
        thresh_nxt.decl_mag = lh_mag;
        thresh_nxt.clr_mag  = lh_mag - `LAD_LH_HYST_DB;
      end
      LAD_MONITOR: begin
        thresh_nxt.decl_mag = `LAD_MON_DECL_MV;
        thresh_nxt.clr_mag  = `LAD_MON_DECL_MV + `LAD_MON_HYST_MV;
      end
      // short-haul fixed level, also for the unused code
      default: begin
        thresh_nxt.decl_mag = `LAD_SH_DECL_MV;
        thresh_nxt.clr_mag  = `LAD_SH_DECL_MV + `LAD_SH_HYST_MV;
      end
    endcase
  end

  // Bit qualifiers taken from the line rails and the bit tick
  wire         mark    = i_line_in.pos | i_line_in.neg;
  wire         tick    = i_bit_tick;
  wire         p_decl  = tick && mark && i_lvl_above_decl;
  wire         p_clr   = tick && mark && i_lvl_above_clr;
  wire         zbit    = tick && !mark;
  wire         absent  = (loss_r == LAD_ABSENT);

  // Declare side
  // N quiet intervals declare loss
  wire         decl_hit = !absent && tick && !p_decl && (decl_cnt == n_val - 12'h001);
  // quiet run restarts on a mark above the declare level
  wire         decl_clr = absent || p_decl;
  wire         decl_inc = tick && !p_decl && !absent;

  // Clear side: a window opened by a good pulse, broken by any failure
  wire         zfail    = zbit && (zrun_cnt >= zmax - 7'h01);
  wire         lfail    = tick && mark && !i_lvl_above_clr;
  wire         fail     = active_r && (zfail || lfail);
  wire         start    = absent && !active_r && p_clr;
  wire         go_on    = active_r && tick && !fail;
  wire  [8:0]  marks    = {1'b0, mark_cnt} + {8'h00, mark};
  wire  [11:0] dens     = {marks, 3'b000};
  wire         win_last = go_on && (win_cnt == m_val - 12'h001);
  // full window with one-in-eight density clears loss
  wire         clr_done = win_last && (dens >= m_val);
  wire         win_clr  = !active_r || fail || win_last;
  wire         win_inc  = start || go_on;

  // Shared interval counters
  lad_run_cnt #(.W(12)) u_decl_cnt (
    .i_clk    (i_core_clk),
    .i_resetn (i_resetn),
    .i_ce     (i_ce),
    .i_clr    (decl_clr),
    .i_inc    (decl_inc),
    .o_count  (decl_cnt)
  );

  lad_run_cnt #(.W(12)) u_win_cnt (
    .i_clk    (i_core_clk),
    .i_resetn (i_resetn),
    .i_ce     (i_ce),
    .i_clr    (win_clr),
    .i_inc    (win_inc),
    .o_count  (win_cnt)
  );

  lad_run_cnt #(.W(8)) u_mark_cnt (
    .i_clk    (i_core_clk),
    .i_resetn (i_resetn),
    .i_ce     (i_ce),
    .i_clr    (win_clr),
    .i_inc    (win_inc && mark),
    .o_count  (mark_cnt)
  );

  lad_run_cnt #(.W(7)) u_zrun_cnt (
    .i_clk    (i_core_clk),
    .i_resetn (i_resetn),
    .i_ce     (i_ce),
    .i_clr    (!active_r || fail || (tick && mark)),
    .i_inc    (go_on && !mark),
    .o_count  (zrun_cnt)
  );

  // Loss state transitions
  always_comb begin
    loss_nxt = loss_r;
    unique case (loss_r)
      LAD_PRESENT: if (decl_hit) begin
        loss_nxt = LAD_ABSENT;
      end
      LAD_ABSENT: if (clr_done) begin
        loss_nxt = LAD_PRESENT;
      end
    endcase
  end

  // Master clock edge drives the all-ones alternation
  wire         mclk_rise = i_master_clock && !mclk_q_r;
  wire         rx_ones   = absent && cfg_r.rx_ones_en;
  wire         tx_ones   = absent && cfg_r.tx_ones_on_absence;
  wire  [1:0]  ones_rail = pol_r ? 2'b10 : 2'b01;

  // Loss state, window flag and ones polarity
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      loss_r   <= LAD_PRESENT;
      active_r <= 1'b0;
      mclk_q_r <= 1'b0;
      pol_r    <= 1'b0;
    end else if (i_ce) begin
      loss_r   <= loss_nxt;
      active_r <= absent && !clr_done && !win_last && (active_r ? !fail : start);
      mclk_q_r <= i_master_clock;
      pol_r    <= mclk_rise ? !pol_r : pol_r;
    end
  end

  // Registered outputs
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_thresh              <= '0;
      o_signal_absent_out   <= 1'b0;
      o_recovered_clock_out <= 1'b0;
      o_rx_rail             <= '0;
      o_line_out            <= '0;
    end else if (i_ce) begin
      o_thresh <= thresh_nxt;
      if (pd) begin
        o_signal_absent_out   <= 1'b0;
        o_recovered_clock_out <= 1'b0;
        o_rx_rail             <= '0;
      end else begin
        o_signal_absent_out   <= (loss_nxt == LAD_ABSENT);
        o_recovered_clock_out <= rx_ones ? i_master_clock : i_recovered_clock;
        // follow line or send all ones
        if (rx_ones) begin
          o_rx_rail <= ones_rail;
        end else if (tick) begin
          o_rx_rail <= i_line_in;
        end
      end
      // line side all ones on master clock
      o_line_out <= tx_ones ? ones_rail : i_tx_data;
    end
  end

  // Alarm-signal detector; E1 alarm sets are equal under both criteria
  lad_alarm_det #(.E1_BLK(E1_BLK), .T1_BLK(T1_BLK)) u_alarm (
    .i_clk    (i_core_clk),
    .i_resetn (i_resetn),
    .i_ce     (i_ce),
    .i_enable (cfg_r.cdr_en && !pd),
    .i_t1     (is_t1),
    .i_tick   (tick),
    .i_mark   (mark),
    .o_status (o_alarm_signal_status)
  );

  a_loss_declare_count: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    $rose(loss_r) |-> $past(decl_cnt) == $past(n_val) - 12'h001)
    else $error("loss declared before N quiet intervals");

  a_loss_clear_window: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    $fell(loss_r) |-> $past(win_cnt) == $past(m_val) - 12'h001 && $past(dens >= m_val))
    else $error("loss cleared without a full dense window");

  a_t1_decl_count: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    $rose(loss_r) && $past(is_t1) |-> $past(decl_cnt) == ($past(crit) ? 12'h607 : 12'h0ae))
    else $error("T1 declare count wrong");

  a_e1_decl_count: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    $rose(loss_r) && !$past(is_t1) |-> $past(decl_cnt) == ($past(crit) ? 12'h7ff : 12'h01f))
    else $error("E1 declare count wrong");

  a_zero_run_limit: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    active_r |-> zrun_cnt < zmax)
    else $error("clear window survived too many zeros");

  a_short_haul_level: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    (i_ce && cfg_r.haul == LAD_SHORT) |=> o_thresh.decl_mag == 12'h320
      && o_thresh.clr_mag == 12'h3e8)
    else $error("short-haul threshold wrong");

  a_long_haul_hyst: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    o_thresh.long_db |-> o_thresh.clr_mag + 12'h004 == o_thresh.decl_mag
      && o_thresh.decl_mag <= 12'h030)
    else $error("long-haul hysteresis wrong");

  a_rx_all_ones: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    (i_ce && rx_ones && !pd) |=> (o_rx_rail.pos ^ o_rx_rail.neg))
    else $error("no ones on system side during loss");

  a_mclk_substitute: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    (i_ce && rx_ones && !pd) |=> o_recovered_clock_out == $past(i_master_clock))
    else $error("recovered clock not replaced");

  a_tx_all_ones: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    (i_ce && tx_ones) ##1 (i_ce && tx_ones) |=> $changed(o_line_out) == $past(mclk_rise, 2))
    else $error("line ones not paced by master clock");

  a_power_down_low: assert property (
    @(posedge i_core_clk) disable iff (!i_resetn)
    (i_ce && pd) |=> !o_signal_absent_out && !o_recovered_clock_out && o_rx_rail == 2'b00)
    else $error("receive outputs active in power-down");

  c_loss_set: cover property (@(posedge i_core_clk) disable iff (!i_resetn) $rose(loss_r));
  c_loss_clear: cover property (@(posedge i_core_clk) disable iff (!i_resetn) $fell(loss_r));
  c_window_fail: cover property (@(posedge i_core_clk) disable iff (!i_resetn) fail);

endmodule

/* File: hdl/lad_map.svh */
// Constant map for the line loss and alarm detector
`ifndef LAD_MAP_SVH
`define LAD_MAP_SVH

// Declare counts in bit intervals
`define LAD_T1_N_STD    12'h0af
`define LAD_T1_N_ALT    12'h608
`define LAD_E1_N_STD    12'h020
`define LAD_E1_N_ALT    12'h800
// Clear window lengths and consecutive-zero limits
`define LAD_T1_M        12'h080
`define LAD_E1_M        12'h020
`define LAD_T1_ZMAX     7'h64
`define LAD_E1_ZMAX     7'h10
// Mark density of one in eight, as a left shift of the mark count
`define LAD_DENS_SHIFT  3
// Amplitude thresholds, mVpp
`define LAD_SH_DECL_MV  12'h320
`define LAD_SH_HYST_MV  12'h0c8
`define LAD_MON_DECL_MV 12'h640
`define LAD_MON_HYST_MV 12'h190
// Long-haul thresholds, dB below nominal
`define LAD_LH_BASE_DB  12'h004
`define LAD_LH_MAX_DB   12'h030
`define LAD_LH_HYST_DB  12'h004
`define LAD_LH_SAT_CODE 5'h16
`define LAD_CODE_RST    5'h15
// Alarm detection windows and zero thresholds
`define LAD_E1_BLK      14'h0200
`define LAD_T1_BLK      14'h2000
`define LAD_E1_ZTHR     4'h3
`define LAD_T1_ZTHR     4'h9
// Configuration reset values
`define LAD_STD_RST     1'b0
`define LAD_CRIT_RST    1'b0
`define LAD_RXONES_RST  1'b0
`define LAD_TXONES_RST  1'b0
`define LAD_CDR_RST     1'b1
`define LAD_PD_RST      1'b0

`endif

/* File: hdl/lad_pkg.sv */
// Types shared by the line loss and alarm detector
package lad_pkg;

  // Receiver operating mode
  typedef enum logic [1:0] {
    LAD_SHORT   = 2'b00,
    LAD_LONG    = 2'b01,
    LAD_MONITOR = 2'b10
  } lad_haul_t;

  // Loss status
  typedef enum logic {
    LAD_PRESENT = 1'b0,
    LAD_ABSENT  = 1'b1
  } lad_loss_t;

  // Configuration word, loaded on a write strobe
  typedef struct packed {
    lad_haul_t haul;
    logic      line_standard_select;
    logic      criteria_select;
    logic      rx_ones_en;
    logic      tx_ones_on_absence;
    logic      cdr_en;
    logic      rx_power_down;
  } lad_cfg_t;

  // Dual-rail data
  typedef struct packed {
    logic pos;
    logic neg;
  } lad_rails_t;

  // Threshold request to the slicer: mVpp or, when long_db, dB below nominal
  typedef struct packed {
    logic        long_db;
    logic [11:0] decl_mag;
    logic [11:0] clr_mag;
  } lad_thresh_t;

endpackage

/* File: hdl/lad_run_cnt.sv */
// Saturating run counter with restart-and-load
`timescale 1ns/100ps
module lad_run_cnt #(
  parameter int W = 12
) (
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  input  wire logic         i_ce,
  input  wire logic         i_clr,
  input  wire logic         i_inc,
  output logic [W-1:0]      o_count
);

  // Restart loads the current increment, otherwise count up to saturation
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_count <= '0;
    end else if (i_ce) begin
      if (i_clr) begin
        o_count <= {{(W-1){1'b0}}, i_inc};
      end else if (i_inc && !(&o_count)) begin
        o_count <= o_count + 1'b1;
      end
    end
  end

endmodule
